// *** core/adc_sequencer.sv ***
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`default_nettype none
module adc_sequencer
  import adc_seq_pkg::*;
#(
  parameter int SLOTS = 8,
  parameter int RES_W = 10
) (
  input wire logic i_ref_clk, // 40 MHz
  input wire logic i_rst_b, // sync reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read valid
  input wire logic s_axi_rready, // read ready
  output conv_req_s o_conv, // to converter core
  output logic o_conv_clk_en, // converter clock enable pulse
  input wire logic i_conv_done, // converter finished, async
  input wire logic [RES_W-1:0] i_conv_data, // stable once done seen
  input wire logic i_pen_touch, // pen comparator, async
  output logic o_pen_bias, // pen detect bias on
  output logic o_touch_bias_supply, // touch reference regulator on
  output plate_drive_s o_plate, // plate switch controls
  output logic o_irq // interrupt, active high
);
  localparam int SW = $clog2(SLOTS);
  localparam int DW = 16;
  localparam int DIV_W = 5;

  typedef enum logic [2:0] {S_IDLE, S_SYNC, S_PRE, S_START, S_WAIT, S_GAP, S_POST} state_e;

  function automatic logic [31:0] apply_strobe(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [DW-1:0] step_delay(input logic [3:0] code);
    return DW'(code) * DW'(STEP_CYCLES);
  endfunction

  // registers
  logic converter_enable, loop_mode, result_freeze, touch_enable, pen_sense_enable;
  logic [SW-1:0] last_slot_index, touch_last_slot;
  logic [3:0] pre_conversion_wait, inter_conversion_wait, post_sequence_wait;
  logic [3:0] slot_channel_select [SLOTS];
  logic [1:0] touch_slot_action [SLOTS];
  logic [RES_W-1:0] conversion_result_slot [SLOTS];
  logic [RES_W-1:0] pending [SLOTS];
  logic sequence_complete_irq, touch_sequence_done_irq, pen_touch_flag;
  logic [2:0] irq_mask;

  // axi holding state
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] wr_val;
  logic [7:0] wr_addr;

  // sequencer state
  state_e state;
  logic touch_run;
  logic [SW-1:0] slot;
  logic [DW-1:0] wait_cnt;
  logic [DIV_W-1:0] div_cnt;
  logic done_m, done_s, done_d;
  logic pen_m, pen_s;
  logic seq_trig, touch_trig;
  logic seq_end_pulse, touch_end_pulse;
  logic [SW-1:0] stop_slot;
  logic last_slot;
  logic [1:0] cur_action;

  // write channel: address and data may arrive in either order
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_addr = aw_addr;
  assign wr_val = w_data;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr[1:0] == 2'h0 && aw_addr <= OFF_MASK) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control register
  logic [31:0] ctrl_now, ctrl_new;
  assign ctrl_now = {19'h0, touch_last_slot, 1'b0, pen_sense_enable, touch_enable,
                     last_slot_index, result_freeze, loop_mode, 1'b0, converter_enable};
  assign ctrl_new = apply_strobe(ctrl_now, wr_val, w_strb);
  logic [31:0] delay_now, delay_new;
  assign delay_now = {20'h0, post_sequence_wait, inter_conversion_wait, pre_conversion_wait};
  assign delay_new = apply_strobe(delay_now, wr_val, w_strb);

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      converter_enable <= 1'b0;
      loop_mode <= 1'b0;
      result_freeze <= 1'b0;
      last_slot_index <= '0;
      touch_enable <= 1'b0;
      pen_sense_enable <= 1'b0;
      touch_last_slot <= '0;
      seq_trig <= 1'b0;
      touch_trig <= 1'b0;
    end else begin
      seq_trig <= 1'b0;
      touch_trig <= 1'b0;
      if (do_write && wr_addr == OFF_CTRL) begin
        converter_enable <= ctrl_new[CTRL_ENABLE];
        loop_mode <= ctrl_new[CTRL_LOOP];
        result_freeze <= ctrl_new[CTRL_FREEZE];
        last_slot_index <= ctrl_new[CTRL_LAST_LSB +: SW];
        touch_enable <= ctrl_new[CTRL_TOUCH_EN];
        pen_sense_enable <= ctrl_new[CTRL_PEN_EN];
        touch_last_slot <= ctrl_new[CTRL_TLAST_LSB +: SW];
        // trigger bits self-clear: a single start pulse
        seq_trig <= ctrl_new[CTRL_TRIGGER];
        touch_trig <= ctrl_new[CTRL_TOUCH_TRIG];
      end
    end
  end

  // delay and selection registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      pre_conversion_wait <= DELAY_RESET;
      inter_conversion_wait <= DELAY_RESET;
      post_sequence_wait <= DELAY_RESET;
      for (int i = 0; i < SLOTS; i++) begin
        slot_channel_select[i] <= 4'h0;
        touch_slot_action[i] <= 2'h0;
      end
      irq_mask <= MASK_RESET;
    end else if (do_write) begin
      if (wr_addr == OFF_DELAY) begin
        {post_sequence_wait, inter_conversion_wait, pre_conversion_wait} <= delay_new[11:0];
      end
      if (wr_addr == OFF_CHSEL) begin
        for (int i = 0; i < SLOTS; i++) begin
          if (w_strb[i/2]) begin
            slot_channel_select[i] <= wr_val[4*i +: 4];
          end
        end
      end
      if (wr_addr == OFF_TSEL) begin
        for (int i = 0; i < SLOTS; i++) begin
          if (w_strb[i/4]) begin
            touch_slot_action[i] <= wr_val[2*i +: 2];
          end
        end
      end
      if (wr_addr == OFF_MASK && w_strb[0]) begin
        irq_mask <= wr_val[2:0];
      end
    end
  end

  // read channel, one cycle after the address is taken
  logic [31:0] rd_val;
  logic rd_ok;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      OFF_CTRL: rd_val = ctrl_now;
      OFF_DELAY: rd_val = delay_now;
      OFF_CHSEL: for (int i = 0; i < SLOTS; i++) rd_val[4*i +: 4] = slot_channel_select[i];
      OFF_TSEL: for (int i = 0; i < SLOTS; i++) rd_val[2*i +: 2] = touch_slot_action[i];
      OFF_STATUS: begin
        rd_val[ST_SEQ_DONE] = sequence_complete_irq;
        rd_val[ST_TOUCH_DONE] = touch_sequence_done_irq;
        rd_val[ST_PEN] = pen_touch_flag;
        rd_val[ST_BUSY] = (state != S_IDLE);
        rd_val[ST_TOUCH_ACT] = touch_run;
      end
      OFF_MASK: rd_val = {29'h0, irq_mask};
      default: begin
        rd_ok = 1'b0;
        for (int r = 0; r < NUM_RESULT_REGS; r++) begin
          if (s_axi_araddr == OFF_RESULT0 + 8'(4 * r)) begin
            rd_ok = 1'b1;
            // two slots per register
            rd_val = {6'h0, conversion_result_slot[2*r+1], 6'h0, conversion_result_slot[2*r]};
          end
        end
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // converter clock enable, 40 MHz / 30
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b || !converter_enable) begin
      div_cnt <= '0;
      o_conv_clk_en <= 1'b0;
    end else begin
      o_conv_clk_en <= (div_cnt == DIV_W'(CONV_DIV - 1));
      div_cnt <= (div_cnt == DIV_W'(CONV_DIV - 1)) ? '0 : div_cnt + 1'b1;
    end
  end

  // synchronisers for analog-side signals
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      done_m <= 1'b0;
      done_s <= 1'b0;
      done_d <= 1'b0;
      pen_m <= 1'b0;
      pen_s <= 1'b0;
    end else begin
      done_m <= i_conv_done;
      done_s <= done_m;
      done_d <= done_s;
      pen_m <= i_pen_touch;
      pen_s <= pen_m;
    end
  end

  logic done_rise;
  assign done_rise = done_s && !done_d;
  assign stop_slot = touch_run ? touch_last_slot : last_slot_index;
  assign last_slot = (slot == stop_slot);
  assign cur_action = touch_slot_action[slot];

  // sequencer
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      state <= S_IDLE;
      touch_run <= 1'b0;
      slot <= '0;
      wait_cnt <= '0;
      seq_end_pulse <= 1'b0;
      touch_end_pulse <= 1'b0;
      o_conv.start <= 1'b0;
      o_conv.channel <= 4'h0;
      o_conv.power <= 1'b0;
      for (int i = 0; i < SLOTS; i++) pending[i] <= '0;
    end else begin
      seq_end_pulse <= 1'b0;
      touch_end_pulse <= 1'b0;
      o_conv.start <= 1'b0;
      o_conv.power <= converter_enable;
      if (!converter_enable) begin
        state <= S_IDLE;
        touch_run <= 1'b0;
      end else if (touch_trig && touch_enable && !touch_run) begin
        // touch preempts a general run; its data overwrites the results
        state <= S_SYNC;
        touch_run <= 1'b1;
        slot <= '0;
        wait_cnt <= DW'(SYNC_CYCLES - 1);
      end else begin
        case (state)
          S_IDLE: begin
            if (seq_trig) begin // ignored unless idle
              state <= S_SYNC;
              touch_run <= 1'b0;
              slot <= '0;
              wait_cnt <= DW'(SYNC_CYCLES - 1);
            end
          end
          S_SYNC: begin
            if (wait_cnt == '0) begin
              state <= S_PRE;
              wait_cnt <= step_delay(pre_conversion_wait);
            end else begin
              wait_cnt <= wait_cnt - 1'b1;
            end
          end
          S_PRE, S_GAP: begin
            if (wait_cnt == '0) begin
              state <= S_START;
            end else begin
              wait_cnt <= wait_cnt - 1'b1;
            end
          end
          S_START: begin
            if (touch_run && cur_action == TACT_DUMMY) begin
              pending[slot] <= '0; // no usable sample; reads zero
              state <= S_WAIT;
            end else begin
              o_conv.start <= 1'b1;
              state <= S_WAIT;
            end
            if (!touch_run) begin
              o_conv.channel <= slot_channel_select[slot];
            end else begin
              case (cur_action)
                TACT_X: o_conv.channel <= CH_Y_PLATE_A;
                TACT_Y: o_conv.channel <= CH_X_PLATE_A;
                TACT_CONTACT: o_conv.channel <= CH_Y_PLATE_B;
                default: o_conv.channel <= CH_X_PLATE_A;
              endcase
            end
          end
          S_WAIT: begin
            if (done_rise || (touch_run && cur_action == TACT_DUMMY)) begin
              if (!(touch_run && cur_action == TACT_DUMMY)) begin
                pending[slot] <= i_conv_data;
              end
              if (!last_slot) begin
                slot <= slot + 1'b1;
                state <= S_GAP;
                wait_cnt <= step_delay(inter_conversion_wait);
              end else begin
                slot <= '0;
                if (touch_run) begin
                  touch_end_pulse <= 1'b1;
                end else begin
                  seq_end_pulse <= 1'b1;
                end
                if (loop_mode && !touch_run) begin
                  state <= S_POST;
                  wait_cnt <= step_delay(post_sequence_wait);
                end else begin
                  state <= S_IDLE;
                  touch_run <= 1'b0;
                end
              end
            end
          end
          S_POST: begin
            if (wait_cnt == '0) begin
              state <= S_START;
            end else begin
              wait_cnt <= wait_cnt - 1'b1;
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // result copy at sequence end; freeze holds them in loop mode, but a touch run end still copies
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      for (int i = 0; i < SLOTS; i++) conversion_result_slot[i] <= '0;
    end else if (touch_end_pulse || (seq_end_pulse && !(loop_mode && result_freeze))) begin
      for (int i = 0; i < SLOTS; i++) begin
        conversion_result_slot[i] <= pending[i];
      end
    end
  end

  // sticky flags, set beats a simultaneous write-one clear
  logic [2:0] clr;
  assign clr = (do_write && wr_addr == OFF_STATUS && w_strb[0]) ? wr_val[2:0] : 3'h0;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      sequence_complete_irq <= 1'b0;
      touch_sequence_done_irq <= 1'b0;
      pen_touch_flag <= 1'b0;
    end else begin
      sequence_complete_irq <= seq_end_pulse ||
                               (sequence_complete_irq && !clr[ST_SEQ_DONE]);
      touch_sequence_done_irq <= touch_end_pulse ||
                                 (touch_sequence_done_irq && !clr[ST_TOUCH_DONE]);
      pen_touch_flag <= (o_pen_bias && pen_s) || (pen_touch_flag && !clr[ST_PEN]);
    end
  end

  // pin-side controls
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_pen_bias <= 1'b0;
      o_touch_bias_supply <= 1'b0;
      o_plate <= '0;
      o_irq <= 1'b0;
    end else begin
      o_pen_bias <= pen_sense_enable && !touch_enable;
      o_touch_bias_supply <= touch_run && touch_enable;
      o_plate.bias_x <= touch_run && cur_action == TACT_X;
      o_plate.bias_y <= touch_run && cur_action == TACT_Y;
      o_plate.current_y_a <= touch_run && cur_action == TACT_CONTACT;
      o_plate.ground_x_b <= touch_run && cur_action == TACT_CONTACT;
      o_plate.differential <= touch_run && cur_action == TACT_CONTACT;
      o_irq <= (sequence_complete_irq && !irq_mask[ST_SEQ_DONE]) ||
               (touch_sequence_done_irq && !irq_mask[ST_TOUCH_DONE]) ||
               (pen_touch_flag && !irq_mask[ST_PEN]);
    end
  end
endmodule
`default_nettype wire

// *** common/adc_seq_pkg.sv ***
// What this block does
// - converter clocked near 1.33 MHz, 10-bit results
// - 4-bit code picks one of sixteen inputs
// - sequence done sets flag, mask gates irq
// - enable before trigger; disabled means low power
// - first conversion waits sync plus pre-delay
// - inter-conversion wait is code times 40 us
// - post-sequence wait only in loop mode
// - delays reset zero, loop mode off
// - slots 0 through stop index, eight max
// - loop mode restarts at slot 0
// - freeze blocks general-sequence result updates in loop mode
// - results stored per slot, four registers
// - backup cell read at two thirds scale
// - pen touch sets flag and unmasked irq
// - pen sense only while touch disabled
// - touch bias on only for touch operation
// - coordinates span 0 to 1023 plate edges
// - X bias X plate, Y bias Y plate
// - contact: current into Y-a, ground X-b
// - touch slots 0 through touch stop index
// - touch action 00 dummy, 01 X, 10 Y
// - touch sequence preempts general sequence
// - dummy conversion result reads zero
// - touch sequence done raises its flag
`default_nettype none
package adc_seq_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DELAY = 8'h04;
  localparam logic [7:0] OFF_CHSEL = 8'h08;
  localparam logic [7:0] OFF_TSEL = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_RESULT0 = 8'h18;
  localparam int NUM_RESULT_REGS = 4;
  // control register fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_TRIGGER = 1;
  localparam int CTRL_LOOP = 2;
  localparam int CTRL_FREEZE = 3;
  localparam int CTRL_LAST_LSB = 4;
  localparam int CTRL_TOUCH_EN = 7;
  localparam int CTRL_PEN_EN = 8;
  localparam int CTRL_TOUCH_TRIG = 9;
  localparam int CTRL_TLAST_LSB = 10;
  // status / mask bits
  localparam int ST_SEQ_DONE = 0;
  localparam int ST_TOUCH_DONE = 1;
  localparam int ST_PEN = 2;
  localparam int ST_BUSY = 8;
  localparam int ST_TOUCH_ACT = 9;
  localparam logic [2:0] MASK_RESET = 3'h0;
  localparam logic [3:0] DELAY_RESET = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int CONV_HZ = 1_333_333;
  localparam int CONV_DIV = CLK_HZ / CONV_HZ;
  localparam int SYNC_US = 30;
  localparam int SYNC_CYCLES = SYNC_US * (CLK_HZ / 1_000_000);
  localparam int STEP_US = 40;
  localparam int STEP_CYCLES = STEP_US * (CLK_HZ / 1_000_000);
  // channel codes
  localparam logic [3:0] CH_DIE_TEMP = 4'h3;
  localparam logic [3:0] CH_BACKUP_CELL = 4'h8;
  localparam logic [3:0] CH_X_PLATE_A = 4'hC;
  localparam logic [3:0] CH_X_PLATE_B = 4'hD;
  localparam logic [3:0] CH_Y_PLATE_A = 4'hE;
  localparam logic [3:0] CH_Y_PLATE_B = 4'hF;
  localparam logic [1:0] TACT_DUMMY = 2'h0;
  localparam logic [1:0] TACT_X = 2'h1;
  localparam logic [1:0] TACT_Y = 2'h2;
  localparam logic [1:0] TACT_CONTACT = 2'h3;

  typedef struct packed {
    logic bias_x;       // bias across x terminals a/b
    logic bias_y;       // bias across y terminals a/b
    logic current_y_a;  // known current into y terminal a
    logic ground_x_b;   // x terminal b grounded
    logic differential; // sense y_b minus x_a
  } plate_drive_s;

  typedef struct packed {
    logic start;          // one-cycle conversion request
    logic [3:0] channel;  // input selected
    logic power;          // converter out of low power
  } conv_req_s;
endpackage
`default_nettype wire

// *** verification/adc_seq_properties.sv ***
`default_nettype none
module adc_seq_properties import adc_seq_pkg::*; (
  input wire logic i_ref_clk, // clock
  input wire logic i_rst_b, // reset, low
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire conv_req_s o_conv, // converter request
  input wire logic o_conv_clk_en, // converter clock pulse
  input wire logic o_pen_bias, // pen bias
  input wire logic o_touch_bias_supply, // touch reference
  input wire plate_drive_s o_plate, // plate switches
  input wire logic o_irq // interrupt
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);
  a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_rvalid_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped early");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_start_pulse: assert property (o_conv.start |=> !o_conv.start)
    else $error("start longer than one cycle");
  a_start_powered: assert property (o_conv.start |-> o_conv.power)
    else $error("start while powered down");
  a_clk_en_spacing: assert property (o_conv_clk_en |=> !o_conv_clk_en [*8])
    else $error("converter clock pulses too close");
  a_bias_exclusive: assert property (o_plate.bias_x |-> !o_plate.bias_y)
    else $error("both plates biased");
  a_contact_drive: assert property (o_plate.current_y_a |->
    o_plate.ground_x_b && o_plate.differential)
    else $error("contact drive incomplete");
  a_pen_touch_excl: assert property (o_touch_bias_supply && $past(o_touch_bias_supply)
    |-> !o_pen_bias)
    else $error("pen bias during touch run");
  a_irq_quiet: assert property ($rose(i_rst_b) |-> !o_irq)
    else $error("irq high out of reset");
endmodule
bind adc_sequencer adc_seq_properties i_props (.*);
`default_nettype wire

// *** verification/adc_conv_model.sv ***
`default_nettype none
module adc_conv_model import adc_seq_pkg::*; (
  input wire logic i_ref_clk, // clock
  input wire conv_req_s i_conv, // request
  input wire logic i_slow, // long conversions
  output logic o_done, // conversion finished
  output logic [9:0] o_data // result
);
  logic [7:0] cnt = 8'h00;
  logic [3:0] ch = 4'h0;
  initial o_done = 1'b0;
  initial o_data = 10'h155;
  always @(posedge i_ref_clk) begin
    if (i_conv.start) begin
      // result invalid while converting, so no stale value slips through
      o_done <= 1'b0;
      o_data <= ~o_data;
      ch <= i_conv.channel;
      cnt <= i_slow ? 8'hC8 : 8'h04;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
      if (cnt == 8'h01) begin
        o_done <= 1'b1;
        o_data <= {ch, 6'h2A};
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/adc_sequencer_touch_readout_test.sv ***
`default_nettype none
module adc_sequencer_touch_readout_test import adc_seq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk = 0, i_rst_b = 0, i_pen_touch = 0, slow = 0, tbias = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic o_conv_clk_en, i_conv_done, o_pen_bias, o_touch_bias_supply, o_irq;
  logic [9:0] i_conv_data;
  conv_req_s o_conv;
  plate_drive_s o_plate;
  int fails = 0, cmp_count = 0, cyc = 0, last = 0, gap = 0, cke = 0, ckp = 0;
  logic [3:0] chq[$];
  plate_drive_s plq[$];
  adc_sequencer i_dut (.*);
  adc_conv_model i_model (.i_ref_clk(i_ref_clk), .i_conv(o_conv), .i_slow(slow),
    .o_done(i_conv_done), .o_data(i_conv_data));
  initial forever #12.5 i_ref_clk = ~i_ref_clk;
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(negedge i_ref_clk) begin
    cyc++;
    if (o_conv.start === 1'b1) begin
      chq.push_back(o_conv.channel);
      plq.push_back(o_plate);
      gap = cyc - last;
      last = cyc;
    end
    if (o_touch_bias_supply === 1'b1) tbias = 1;
    if (o_conv_clk_en === 1'b1) begin
      ckp = cyc - cke;
      cke = cyc;
    end
    if (cyc == 40000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  function automatic logic [15:0] res(input logic [3:0] c);
    return {6'h00, c, 6'h2A};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w, b;
    @(posedge i_ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b = 0;
    while (!b) begin
      @(negedge i_ref_clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge i_ref_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar, b;
    @(posedge i_ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    b = 0;
    while (!b) begin
      @(negedge i_ref_clk);
      ar = s_axi_arvalid && s_axi_arready;
      b = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge i_ref_clk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_st(input int k);
    repeat (4000) begin
      rd(OFF_STATUS);
      if (d[k] === 1'b1) break;
    end
  endtask
  task automatic wq(input int n);
    for (int i = 0; i < 4000 && chq.size() < n; i++) @(posedge i_ref_clk);
  endtask
  task automatic t_reset;
    rd(OFF_DELAY);
    chk(d, 32'h0);
    rd(OFF_CTRL);
    chk(d, 32'h0);
    rd(8'hFC);
    chk(32'(r), 32'(RESP_SLVERR));
  endtask
  task automatic t_seq;
    int t0;
    wr(OFF_DELAY, 32'h11);
    wr(OFF_CHSEL, 32'h983);
    wr(OFF_CTRL, 32'h1);
    chq.delete();
    wr(OFF_CTRL, 32'h23);
    t0 = cyc;
    wq(1);
    chk(32'(last - t0 >= 2800 && last - t0 < 2830), 32'h1);
    chk(32'(ckp), 32'(CONV_DIV));
    wr(OFF_CTRL, 32'h23);
    wait_st(ST_SEQ_DONE);
    chk(32'(chq.size()), 32'h3);
    chk(32'(gap >= 1600 && gap < 1650), 32'h1);
    rd(OFF_RESULT0);
    chk(d, {res(4'h8), res(CH_DIE_TEMP)});
    rd(OFF_RESULT0 + 8'h04);
    chk(32'(d[15:0]), 32'(res(4'h9)));
    chk(32'(o_irq), 32'h1);
    wr(OFF_MASK, 32'h1);
    rd(OFF_STATUS);
    chk(32'(o_irq), 32'h0);
    wr(OFF_STATUS, 32'h1);
    wr(OFF_MASK, 32'h0);
  endtask
  task automatic t_loop;
    wr(OFF_CHSEL, 32'h9);
    chq.delete();
    wr(OFF_CTRL, 32'h7);
    wq(3);
    rd(OFF_RESULT0);
    chk(32'(d[15:0]), 32'(res(4'h9)));
    wr(OFF_CTRL, 32'hD);
    wr(OFF_CHSEL, 32'hB);
    wq(chq.size() + 3);
    rd(OFF_RESULT0);
    chk(32'(d[15:0]), 32'(res(4'h9)));
    wr(OFF_CTRL, 32'h5);
    wq(chq.size() + 3);
    rd(OFF_RESULT0);
    chk(32'(d[15:0]), 32'(res(4'hB)));
    wr(OFF_CTRL, 32'h0);
    rd(OFF_STATUS);
    chk(32'(o_conv.power), 32'h0);
  endtask
  task automatic t_touch;
    wr(OFF_STATUS, 32'h7);
    wr(OFF_TSEL, 32'hE4);
    wr(OFF_CTRL, 32'h81);
    slow = 1;
    tbias = 0;
    chq.delete();
    plq.delete();
    wr(OFF_CTRL, 32'hE81);
    wait_st(ST_TOUCH_DONE);
    chk(32'(chq.size()), 32'h3);
    chk(32'(chq[0]), 32'(CH_Y_PLATE_A));
    chk(32'(chq[1]), 32'(CH_X_PLATE_A));
    chk(32'({plq[0], plq[1], plq[2]}), 32'h4107);
    chk(32'(tbias), 32'h1);
    chk(32'(o_touch_bias_supply), 32'h0);
    rd(OFF_RESULT0);
    chk(d, {res(CH_Y_PLATE_A), 16'h0});
    rd(OFF_RESULT0 + 8'h04);
    chk(d, {res(CH_Y_PLATE_B), res(CH_X_PLATE_A)});
    wr(OFF_CTRL, 32'h0);
    slow = 0;
  endtask
  task automatic t_pen;
    wr(OFF_STATUS, 32'h7);
    wr(OFF_CTRL, 32'h100);
    rd(OFF_STATUS);
    chk(32'(o_pen_bias), 32'h1);
    i_pen_touch <= 1'b1;
    rd(OFF_STATUS);
    rd(OFF_STATUS);
    chk(32'(d[ST_PEN]), 32'h1);
    chk(32'(o_irq), 32'h1);
    i_pen_touch <= 1'b0;
    rd(OFF_STATUS);
    wr(OFF_STATUS, 32'h4);
    wr(OFF_CTRL, 32'h180);
    i_pen_touch <= 1'b1;
    rd(OFF_STATUS);
    rd(OFF_STATUS);
    chk(32'(d[ST_PEN]), 32'h0);
    chk(32'(o_pen_bias), 32'h0);
    i_pen_touch <= 1'b0;
  endtask
  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    t_reset();
    t_seq();
    t_loop();
    t_touch();
    t_pen();
    wrap_up();
  end
endmodule
`default_nettype wire
